// >>> ist_pkg.sv
// Package: constants, bit positions and error codes of the status and trigger block
// ==========================================================================
// Functional notes
// - Errors queue first-in first-out; each error query returns and removes the oldest.
// - Empty error queue answers code zero, the no-error entry.
// - On overflow the last queue entry becomes the too-many-errors code.
// - Front-panel errors bypass the remote queue and go straight to the display.
// - Version query returns language revision as year, point and revision digit.
// - Trigger commands act only in fixed output mode; otherwise ignored.
// - Abort cancels trigger, copies immediate levels to pending, clears await_trigger.
// - With continuous arm on, abort re-arms at once and sets await_trigger.
// - Abort runs automatically at power-up, state recall and reset command.
// - Initiate arms; a bus trigger then applies triggered level; unarmed triggers ignored.
// - Continuous arm takes 1/0, resets off; controller initiates each trigger when off.
// - Armed trigger starts level change, clears await_trigger; continuous arm re-arms it.
// - Trigger source accepts only bus and resets to bus.
// - Run status condition is live, read-only and never cleared.
// - Event latch holds filtered transitions; cleared by reading or clear-status.
// - Status byte bit 7 is OR of enabled run status events.
// - Rising filter cleared by writing zero; falling filter and mask also by preset.
// - Run status bits: calibration 0, await_trigger 5, voltage mode 8, current mode 10.
// - Fault bits: voltage trip 0, current trip 1, thermal 4, inhibit 9, regulation 10.
// - Standard event bits: 0, 2, 3, 4, 5 and power-up at 7.
// - Status byte bits: fault 3, message 4, std event 5, master 6, run 7.
// - Rising filter passes 0-to-1, falling filter passes 1-to-0; zero passes none.
// - Status preset loads rising filter with 1313, clears falling filter and mask.
package ist_pkg;
  // ==========================================================================
  // Register selectors
  localparam logic [2:0] SEL_COND    = 3'h0;
  localparam logic [2:0] SEL_RISE    = 3'h1;
  localparam logic [2:0] SEL_FALL    = 3'h2;
  localparam logic [2:0] SEL_EVENT   = 3'h3;
  localparam logic [2:0] SEL_ENABLE  = 3'h4;
  localparam logic [2:0] SEL_FAULT   = 3'h5;
  localparam logic [2:0] SEL_STDEVT  = 3'h6;
  localparam logic [2:0] SEL_SUMMARY = 3'h7;
  // ==========================================================================
  // Run status bit positions
  localparam int RUN_CAL_BIT   = 0;
  localparam int RUN_AWAIT_BIT = 5;
  localparam int RUN_CV_BIT    = 8;
  localparam int RUN_CC_BIT    = 10;
  // Fault status bit positions
  localparam int FLT_OV_BIT  = 0;
  localparam int FLT_OC_BIT  = 1;
  localparam int FLT_OT_BIT  = 4;
  localparam int FLT_RI_BIT  = 9;
  localparam int FLT_UNR_BIT = 10;
  // Standard event bit positions
  localparam int STD_OPC_BIT = 0;
  localparam int STD_QYE_BIT = 2;
  localparam int STD_DDE_BIT = 3;
  localparam int STD_EXE_BIT = 4;
  localparam int STD_CME_BIT = 5;
  localparam int STD_PON_BIT = 7;
  // Summary byte bit positions
  localparam int SB_FAULT_BIT = 3;
  localparam int SB_MAV_BIT   = 4;
  localparam int SB_ESB_BIT   = 5;
  localparam int SB_MSS_BIT   = 6;
  localparam int SB_RUN_BIT   = 7;
  // ==========================================================================
  // Reset and preset values
  localparam logic [15:0] RISE_PRESET  = 16'h0521; // 1313
  localparam logic [15:0] RISE_RESET   = 16'h0521;
  localparam logic [15:0] ZERO16       = 16'h0000;
  localparam logic [15:0] RUN_DEF_MASK = 16'h0521;
  localparam logic [15:0] FLT_DEF_MASK = 16'h0613;
  // Error codes
  localparam logic signed [15:0] ERR_NONE     = 16'sh0000;
  localparam logic signed [15:0] ERR_OVERFLOW = -16'sh015E; // -350
  // Language revision YYYY.V
  localparam logic [15:0] VER_YEAR = 16'h07CF;
  localparam logic [3:0]  VER_REV  = 4'h0;
  // ==========================================================================
  // Trigger states, Gray along idle -> armed -> firing
  typedef enum logic [1:0] {
    TRG_IDLE  = 2'b00,
    TRG_ARMED = 2'b01,
    TRG_FIRE  = 2'b11
  } ist_trg_state_t;
endpackage : ist_pkg

// >>> ist_err_fifo.sv
// Remote error queue with overflow marker in the last slot
`timescale 1ns/1ps
module ist_err_fifo #(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  // Push side
  input  wire logic               push_i,
  input  wire logic signed [15:0] code_i,
  // Pop side
  input  wire logic               pop_i,
  output logic signed [15:0]      code_o,
  output logic                    empty_o
);
  localparam int AW = $clog2(DEPTH);
  logic signed [15:0] mem_reg [DEPTH];
  logic [AW-1:0]      rd_reg;
  logic [AW-1:0]      wr_reg;
  logic [AW:0]        cnt_reg;
  logic               do_pop;
  logic               do_push;

  // Pop only when an entry exists; push while room remains
  assign do_pop  = pop_i && (cnt_reg != '0);
  assign do_push = push_i && (cnt_reg < (AW+1)'(DEPTH) || do_pop);
  assign empty_o = (cnt_reg == '0);
  assign code_o  = empty_o ? ist_pkg::ERR_NONE : mem_reg[rd_reg];

  // Storage: the final free slot takes the overflow code instead of the error
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < DEPTH; i++) mem_reg[i] <= 16'sh0000;
    end else if (do_push) begin
      if (cnt_reg == (AW+1)'(DEPTH-1) && !do_pop)
        mem_reg[wr_reg] <= ist_pkg::ERR_OVERFLOW;
      else
        mem_reg[wr_reg] <= code_i;
    end
  end

  // Pointers and fill count; oldest entry leaves on each query
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_reg  <= '0;
      wr_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_push) wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (do_pop)  rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // Once full, only the overflow marker stands in the tail slot
  chk_overflow_tail: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    push_i && !pop_i && cnt_reg == (AW+1)'(DEPTH-1)
    |=> mem_reg[$past(wr_reg)] == ist_pkg::ERR_OVERFLOW)
    else $error("overflow code not in last slot");
endmodule : ist_err_fifo

// >>> ist_status_trigger.sv
// Top level: status registers, trigger state machine, error and version answers
`timescale 1ns/1ps
module ist_status_trigger #(
  parameter int ERR_DEPTH = 8
) (
  // Clock and reset
  input  wire logic               CLK_I,
  input  wire logic               RST_B_I,
  // Instrument mode and live conditions (asynchronous)
  input  wire logic               FIXED_MODE_I,
  input  wire logic               CAL_BUSY_I,
  input  wire logic               CONST_VOLTAGE_MODE_I,
  input  wire logic               CONST_CURRENT_MODE_I,
  input  wire logic               HIGH_VOLTAGE_TRIP_I,
  input  wire logic               EXCESS_CURRENT_TRIP_I,
  input  wire logic               THERMAL_FAULT_I,
  input  wire logic               REMOTE_INHIBIT_I,
  input  wire logic               REGULATION_LOST_I,
  input  wire logic               MESSAGE_AVAILABLE_I,
  // Command strobes from the parser
  input  wire logic               ABORT_CMD_I,
  input  wire logic               INIT_CMD_I,
  input  wire logic               TRIG_CMD_I,
  input  wire logic               RECALL_CMD_I,
  input  wire logic               RESET_CMD_I,
  input  wire logic               CLEAR_STATUS_I,
  input  wire logic               STATUS_PRESET_I,
  input  wire logic               CONT_ARM_WR_I,
  input  wire logic               CONT_ARM_VAL_I,
  input  wire logic               TRIG_SRC_WR_I,
  input  wire logic               TRIG_SRC_BUS_I,
  // Register access
  input  wire logic               REG_WR_I,
  input  wire logic               REG_RD_I,
  input  wire logic [2:0]         REG_SEL_I,
  input  wire logic [15:0]        REG_WDATA_I,
  output logic [15:0]             REG_RDATA_O,
  // Standard events and errors
  input  wire logic [7:0]         STD_EVENT_SET_I,
  input  wire logic               ERR_PUSH_I,
  input  wire logic signed [15:0] ERR_CODE_I,
  input  wire logic               ERR_LOCAL_I,
  input  wire logic               ERR_QUERY_I,
  output logic signed [15:0]      ERR_CODE_O,
  output logic                    ERR_VALID_O,
  output logic signed [15:0]      PANEL_ERR_O,
  output logic                    PANEL_ERR_STB_O,
  // Version answer
  output logic [15:0]             VERSION_YEAR_O,
  output logic [3:0]              VERSION_REV_O,
  // Trigger outputs and summary byte
  output logic                    LEVEL_APPLY_O,
  output logic                    LEVEL_RESYNC_O,
  output logic                    CONT_ARM_O,
  output logic                    TRIG_SRC_BUS_O,
  output logic                    AWAIT_TRIGGER_O,
  output logic [7:0]              SUMMARY_BYTE_O
);
  // ==========================================================================
  // Input synchronisers
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] meta_reg;
  logic [NSYNC-1:0] sync_reg;
  assign async_in = {MESSAGE_AVAILABLE_I, REGULATION_LOST_I, REMOTE_INHIBIT_I,
                     THERMAL_FAULT_I, EXCESS_CURRENT_TRIP_I, HIGH_VOLTAGE_TRIP_I,
                     CONST_CURRENT_MODE_I, CONST_VOLTAGE_MODE_I, CAL_BUSY_I,
                     FIXED_MODE_I};

  // Two-stage capture; only the second stage is read by logic
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end
  logic fixed_mode;
  assign fixed_mode = sync_reg[0];

  // ==========================================================================
  // Trigger state machine
  ist_pkg::ist_trg_state_t trg_reg;
  ist_pkg::ist_trg_state_t trg_next;
  logic cont_arm_reg;
  logic src_bus_reg;
  logic pwr_abort_reg;
  logic abort_req;
  logic trig_hit;

  // Power-up abort fires once after reset release
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) pwr_abort_reg <= 1'b1;
    else          pwr_abort_reg <= 1'b0;
  end

  // Abort also on recall and reset; bus commands count only in fixed mode
  assign abort_req = pwr_abort_reg || RECALL_CMD_I || RESET_CMD_I
                   || (ABORT_CMD_I && fixed_mode);
  assign trig_hit  = TRIG_CMD_I && fixed_mode && src_bus_reg && trg_reg == ist_pkg::TRG_ARMED;

  // Continuous arm setting; reset command forces it off
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I)
      cont_arm_reg <= 1'b0;
    else if (RESET_CMD_I)
      cont_arm_reg <= 1'b0;
    else if (CONT_ARM_WR_I && fixed_mode)
      cont_arm_reg <= CONT_ARM_VAL_I;
  end

  // Source select: only bus is legal, so other choices are dropped
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I)
      src_bus_reg <= 1'b1;
    else if (RESET_CMD_I)
      src_bus_reg <= 1'b1;
    else if (TRIG_SRC_WR_I && TRIG_SRC_BUS_I && fixed_mode)
      src_bus_reg <= 1'b1;
  end

  // Next state: abort beats everything, firing lasts one cycle
  always_comb begin
    trg_next = trg_reg;
    case (trg_reg)
      ist_pkg::TRG_IDLE: begin
        if (INIT_CMD_I && fixed_mode) trg_next = ist_pkg::TRG_ARMED;
      end
      ist_pkg::TRG_ARMED: begin
        if (trig_hit) trg_next = ist_pkg::TRG_FIRE;
      end
      ist_pkg::TRG_FIRE: begin
        trg_next = cont_arm_reg ? ist_pkg::TRG_ARMED : ist_pkg::TRG_IDLE;
      end
      default: trg_next = ist_pkg::TRG_IDLE;
    endcase
    // Reset command turns continuous arm off, so its abort must not re-arm
    if (abort_req)
      trg_next = (cont_arm_reg && !RESET_CMD_I) ? ist_pkg::TRG_ARMED : ist_pkg::TRG_IDLE;
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) trg_reg <= ist_pkg::TRG_IDLE;
    else          trg_reg <= trg_next;
  end

  // Level strobes: apply pending on trigger, resync pending to immediate on abort
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      LEVEL_APPLY_O  <= 1'b0;
      LEVEL_RESYNC_O <= 1'b0;
    end else begin
      LEVEL_APPLY_O  <= trig_hit && !abort_req;
      LEVEL_RESYNC_O <= abort_req;
    end
  end
  logic await_next;
  assign await_next = (trg_next == ist_pkg::TRG_ARMED);

  // ==========================================================================
  // Run status group
  logic [15:0] cond_reg;
  logic [15:0] cond_next;
  logic [15:0] prev_reg;
  logic [15:0] rise_reg;
  logic [15:0] fall_reg;
  logic [15:0] event_reg;
  logic [15:0] enable_reg;
  logic [15:0] fault_reg;
  logic [15:0] edge_hits;

  // Live condition word, built every cycle
  always_comb begin
    cond_next = '0;
    cond_next[ist_pkg::RUN_CAL_BIT]   = sync_reg[1];
    cond_next[ist_pkg::RUN_AWAIT_BIT] = await_next;
    cond_next[ist_pkg::RUN_CV_BIT]    = sync_reg[2];
    cond_next[ist_pkg::RUN_CC_BIT]    = sync_reg[3];
  end

  // Condition has no write path at all
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cond_reg <= '0;
      prev_reg <= '0;
    end else begin
      cond_reg <= cond_next;
      prev_reg <= cond_reg;
    end
  end

  // Fault condition word
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) fault_reg <= '0;
    else begin
      fault_reg <= '0;
      fault_reg[ist_pkg::FLT_OV_BIT]  <= sync_reg[4];
      fault_reg[ist_pkg::FLT_OC_BIT]  <= sync_reg[5];
      fault_reg[ist_pkg::FLT_OT_BIT]  <= sync_reg[6];
      fault_reg[ist_pkg::FLT_RI_BIT]  <= sync_reg[7];
      fault_reg[ist_pkg::FLT_UNR_BIT] <= sync_reg[8];
    end
  end

  // Per-bit filters against last cycle's condition
  assign edge_hits = (rise_reg & cond_reg & ~prev_reg)
                   | (fall_reg & ~cond_reg & prev_reg);
  logic rd_event;
  logic wr_rise;
  logic wr_fall;
  logic wr_enable;
  assign rd_event  = REG_RD_I && REG_SEL_I == ist_pkg::SEL_EVENT;
  assign wr_rise   = REG_WR_I && REG_SEL_I == ist_pkg::SEL_RISE;
  assign wr_fall   = REG_WR_I && REG_SEL_I == ist_pkg::SEL_FALL;
  assign wr_enable = REG_WR_I && REG_SEL_I == ist_pkg::SEL_ENABLE;
  // Filters and mask; preset loads the default rising pattern
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rise_reg   <= ist_pkg::RISE_RESET;
      fall_reg   <= ist_pkg::ZERO16;
      enable_reg <= ist_pkg::ZERO16;
    end else if (STATUS_PRESET_I) begin
      rise_reg   <= ist_pkg::RISE_PRESET;
      fall_reg   <= ist_pkg::ZERO16;
      enable_reg <= ist_pkg::ZERO16;
    end else begin
      if (wr_rise)   rise_reg   <= REG_WDATA_I;
      if (wr_fall)   fall_reg   <= REG_WDATA_I;
      if (wr_enable) enable_reg <= REG_WDATA_I;
    end
  end
  // Event latch: new hits win over a read or clear in the same cycle
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) event_reg <= '0;
    else if (rd_event || CLEAR_STATUS_I) event_reg <= edge_hits;
    else event_reg <= event_reg | edge_hits;
  end

  // ==========================================================================
  // Standard event latch
  logic [7:0] std_reg;
  logic       rd_std;
  assign rd_std = REG_RD_I && REG_SEL_I == ist_pkg::SEL_STDEVT;

  // Power-up bit set once out of reset; sets win over read clears
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) std_reg <= '0;
    else if (rd_std || CLEAR_STATUS_I)
      std_reg <= STD_EVENT_SET_I | {pwr_abort_reg, 7'h00};
    else
      std_reg <= std_reg | STD_EVENT_SET_I | {pwr_abort_reg, 7'h00};
  end

  // ==========================================================================
  // Summary byte; run bit built from next event value so it moves with the event latch
  logic [15:0] event_next;
  logic [7:0]  sb_next;
  assign event_next = ((rd_event || CLEAR_STATUS_I) ? 16'h0000 : event_reg) | edge_hits;
  always_comb begin
    sb_next = '0;
    sb_next[ist_pkg::SB_FAULT_BIT] = |fault_reg;
    sb_next[ist_pkg::SB_MAV_BIT]   = sync_reg[9];
    sb_next[ist_pkg::SB_ESB_BIT]   = |std_reg;
    sb_next[ist_pkg::SB_RUN_BIT]   = |(event_next & enable_reg);
    sb_next[ist_pkg::SB_MSS_BIT]   = sb_next[ist_pkg::SB_FAULT_BIT] | sb_next[ist_pkg::SB_ESB_BIT]
                                   | sb_next[ist_pkg::SB_RUN_BIT];
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) SUMMARY_BYTE_O <= '0;
    else          SUMMARY_BYTE_O <= sb_next;
  end

  // ==========================================================================
  // Error queue; local errors go to the panel instead
  logic signed [15:0] fifo_code;
  logic               fifo_empty;
  ist_err_fifo #(.DEPTH(ERR_DEPTH)) u_err_fifo (
    .clk_i   (CLK_I),
    .rst_b_i (RST_B_I),
    .push_i  (ERR_PUSH_I && !ERR_LOCAL_I),
    .code_i  (ERR_CODE_I),
    .pop_i   (ERR_QUERY_I),
    .code_o  (fifo_code),
    .empty_o (fifo_empty)
  );

  // Answer registered on each query: oldest code, or zero when empty
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ERR_CODE_O      <= ist_pkg::ERR_NONE;
      ERR_VALID_O     <= 1'b0;
      PANEL_ERR_O     <= ist_pkg::ERR_NONE;
      PANEL_ERR_STB_O <= 1'b0;
    end else begin
      ERR_VALID_O     <= ERR_QUERY_I;
      if (ERR_QUERY_I) ERR_CODE_O <= fifo_code;
      PANEL_ERR_STB_O <= ERR_PUSH_I && ERR_LOCAL_I;
      if (ERR_PUSH_I && ERR_LOCAL_I) PANEL_ERR_O <= ERR_CODE_I;
    end
  end

  // ==========================================================================
  // Register read mux and plain outputs
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      REG_RDATA_O     <= '0;
      VERSION_YEAR_O  <= '0;
      VERSION_REV_O   <= '0;
      CONT_ARM_O      <= 1'b0;
      TRIG_SRC_BUS_O  <= 1'b1;
      AWAIT_TRIGGER_O <= 1'b0;
    end else begin
      VERSION_YEAR_O  <= ist_pkg::VER_YEAR;
      VERSION_REV_O   <= ist_pkg::VER_REV;
      CONT_ARM_O      <= cont_arm_reg;
      TRIG_SRC_BUS_O  <= src_bus_reg;
      AWAIT_TRIGGER_O <= await_next;
      if (REG_RD_I) begin
        case (REG_SEL_I)
          ist_pkg::SEL_COND:    REG_RDATA_O <= cond_reg;
          ist_pkg::SEL_RISE:    REG_RDATA_O <= rise_reg;
          ist_pkg::SEL_FALL:    REG_RDATA_O <= fall_reg;
          ist_pkg::SEL_EVENT:   REG_RDATA_O <= event_reg;
          ist_pkg::SEL_ENABLE:  REG_RDATA_O <= enable_reg;
          ist_pkg::SEL_FAULT:   REG_RDATA_O <= fault_reg;
          ist_pkg::SEL_STDEVT:  REG_RDATA_O <= {8'h00, std_reg};
          ist_pkg::SEL_SUMMARY: REG_RDATA_O <= {8'h00, sb_next};
          default:              REG_RDATA_O <= '0;
        endcase
      end
    end
  end

  // ==========================================================================
  // Checks
  sequence s_fire;
    trg_reg == ist_pkg::TRG_ARMED && trig_hit && !abort_req;
  endsequence
  chk_abort_clears_wait: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    abort_req && (!cont_arm_reg || RESET_CMD_I)
    |=> !cond_reg[ist_pkg::RUN_AWAIT_BIT] && trg_reg == ist_pkg::TRG_IDLE)
    else $error("abort left trigger armed");
  chk_abort_rearm: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    abort_req && cont_arm_reg && !RESET_CMD_I
    |=> trg_reg == ist_pkg::TRG_ARMED && cond_reg[ist_pkg::RUN_AWAIT_BIT])
    else $error("continuous arm did not re-arm after abort");
  chk_not_fixed_ignored: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !fixed_mode && trg_reg == ist_pkg::TRG_IDLE && !abort_req |=> trg_reg == ist_pkg::TRG_IDLE)
    else $error("trigger moved outside fixed mode");
  chk_trigger_applies: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    s_fire |=> LEVEL_APPLY_O
    ##1 (trg_reg == (cont_arm_reg ? ist_pkg::TRG_ARMED : ist_pkg::TRG_IDLE)))
    else $error("armed trigger not applied");
  chk_unarmed_ignored: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    TRIG_CMD_I && trg_reg == ist_pkg::TRG_IDLE |=> !LEVEL_APPLY_O)
    else $error("unarmed trigger acted");
  chk_run_summary: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    ##1 SUMMARY_BYTE_O[ist_pkg::SB_RUN_BIT] == |(event_reg & $past(enable_reg)))
    else $error("run summary mismatch");
  chk_rise_latch: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (|(rise_reg & cond_reg & ~prev_reg)) |=> |event_reg)
    else $error("rising change not latched");
  chk_preset_load: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    STATUS_PRESET_I |=> rise_reg == ist_pkg::RISE_PRESET && fall_reg == '0 && enable_reg == '0)
    else $error("preset values wrong");
endmodule : ist_status_trigger

// >>> ist_ctrl_model.sv
// Bus controller model that issues trigger command strobes
`timescale 1ns/1ps
module ist_ctrl_model (
  // Clock
  input  wire logic clk_i,
  // Strobes: 0 abort, 1 init, 2 trig, 3 continuous arm write
  output logic [3:0] cmd_o
);
  initial cmd_o = 4'h0;
  // One-cycle strobe, launched and dropped on rising edges
  task automatic send(input int b);
    @(posedge clk_i) cmd_o[b] <= 1'b1;
    @(posedge clk_i) cmd_o <= 4'h0;
  endtask : send
endmodule : ist_ctrl_model

// >>> ist_status_trigger_tb.sv
// Self-checking bench of the status and trigger block
`timescale 1ns/1ps
module ist_status_trigger_tb;
  // ====
  // Stimulus and observed signals
  logic               clk = 1'b0;
  logic               rst_b = 1'b0;
  logic [9:0]         lv = 10'h001; // Fixed mode, then live conditions
  logic [7:0]         st = 8'h00; // wr rd push query recall reset clear preset
  logic [7:0]         se = 8'h00; // Standard event set pulses
  logic [3:0]         cmd;
  logic               cval = 1'b0;
  logic               loc = 1'b0;
  logic [2:0]         sel = 3'h0;
  logic [15:0]        wd = 16'h0000;
  logic signed [15:0] ec = 16'sh0000;
  logic [15:0]        rdat, yr;
  logic [3:0]         rev;
  logic signed [15:0] eo, po;
  logic               ev, ps, la, lr, ca, sb, aw;
  logic [7:0]         sum;
  int                 num_errors = 0;
  int                 comparisons = 0;
  int                 n_la = 0;
  int                 n_lr = 0;
  int                 n_ps = 0;
  // Strobes stand one cycle, so each is counted once at a rising edge
  always @(posedge clk) begin
    if (la === 1'b1) n_la++;
    if (lr === 1'b1) n_lr++;
    if (ps === 1'b1) n_ps++;
  end
  initial forever #10 clk = ~clk;
  ist_ctrl_model u_ist_ctrl_model (.clk_i(clk), .cmd_o(cmd));
  ist_status_trigger #(.ERR_DEPTH(3)) u_ist_status_trigger (
    .CLK_I(clk), .RST_B_I(rst_b), .FIXED_MODE_I(lv[0]), .CAL_BUSY_I(lv[1]),
    .CONST_VOLTAGE_MODE_I(lv[2]), .CONST_CURRENT_MODE_I(lv[3]), .HIGH_VOLTAGE_TRIP_I(lv[4]),
    .EXCESS_CURRENT_TRIP_I(lv[5]), .THERMAL_FAULT_I(lv[6]), .REMOTE_INHIBIT_I(lv[7]),
    .REGULATION_LOST_I(lv[8]), .MESSAGE_AVAILABLE_I(lv[9]), .ABORT_CMD_I(cmd[0]),
    .INIT_CMD_I(cmd[1]), .TRIG_CMD_I(cmd[2]), .RECALL_CMD_I(st[4]), .RESET_CMD_I(st[5]),
    .CLEAR_STATUS_I(st[6]), .STATUS_PRESET_I(st[7]), .CONT_ARM_WR_I(cmd[3]),
    .CONT_ARM_VAL_I(cval), .TRIG_SRC_WR_I(1'b0), .TRIG_SRC_BUS_I(1'b1), .REG_WR_I(st[0]),
    .REG_RD_I(st[1]), .REG_SEL_I(sel), .REG_WDATA_I(wd), .REG_RDATA_O(rdat),
    .STD_EVENT_SET_I(se), .ERR_PUSH_I(st[2]), .ERR_CODE_I(ec), .ERR_LOCAL_I(loc),
    .ERR_QUERY_I(st[3]), .ERR_CODE_O(eo), .ERR_VALID_O(ev), .PANEL_ERR_O(po),
    .PANEL_ERR_STB_O(ps), .VERSION_YEAR_O(yr), .VERSION_REV_O(rev), .LEVEL_APPLY_O(la),
    .LEVEL_RESYNC_O(lr), .CONT_ARM_O(ca), .TRIG_SRC_BUS_O(sb), .AWAIT_TRIGGER_O(aw),
    .SUMMARY_BYTE_O(sum));
  // ====
  // Shared tasks
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  // A gap edge between strobes keeps each driver write unique per step
  task automatic pul(input int b);
    @(posedge clk) st[b] <= 1'b1;
    @(posedge clk) st <= 8'h00;
  endtask : pul
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  task automatic rreg(input logic [2:0] s, input logic [15:0] e);
    @(posedge clk) sel <= s;
    pul(1);
    wt(2);
    cmp(rdat, e);
  endtask : rreg
  task automatic wreg(input logic [2:0] s, input logic [15:0] d);
    @(posedge clk) sel <= s;
    wd <= d;
    pul(0);
  endtask : wreg
  task automatic pe(input logic [15:0] c, input logic l);
    @(posedge clk) ec <= c;
    loc <= l;
    pul(2);
  endtask : pe
  task automatic qe(input logic [15:0] e);
    pul(3);
    wt(2);
    cmp(eo, e);
  endtask : qe
  task automatic stop_test();
    $display("num_errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // ====
  // Scenarios
  task automatic s_reset();
    cmp(16'(sb), 16'h0001);
    cmp(16'(ca), 16'h0000);
    cmp(yr, ist_pkg::VER_YEAR);
    cmp(16'(rev), 16'(ist_pkg::VER_REV));
    cmp(16'(n_lr), 16'h0001);
    rreg(ist_pkg::SEL_STDEVT, 16'h0080);
  endtask : s_reset
  // Depth three with four pushes: overflow code takes the last slot
  task automatic s_errors();
    qe(16'h0000);
    pe(16'hFF9C, 1'b0);
    pe(16'hFF38, 1'b0);
    pe(16'hFED4, 1'b0);
    pe(16'hFE70, 1'b0);
    pe(16'hFFFB, 1'b1);
    wt(2);
    cmp(16'(n_ps), 16'h0001);
    cmp(po, 16'hFFFB);
    qe(16'hFF9C);
    qe(16'hFF38);
    qe(16'hFEA2);
    qe(16'h0000);
  endtask : s_errors
  task automatic s_trig();
    u_ist_ctrl_model.send(2);
    wt(4);
    cmp(16'(n_la), 16'h0000);
    u_ist_ctrl_model.send(1);
    wt(3);
    cmp(16'(aw), 16'h0001);
    u_ist_ctrl_model.send(2);
    wt(4);
    cmp(16'({n_la[3:0], aw}), 16'h0002);
    @(posedge clk) cval <= 1'b1;
    u_ist_ctrl_model.send(3);
    u_ist_ctrl_model.send(0);
    wt(4);
    cmp(16'({n_lr[3:0], ca, aw}), 16'h000B);
    u_ist_ctrl_model.send(2);
    wt(4);
    cmp(16'({n_la[3:0], aw}), 16'h0005);
    @(posedge clk) lv[0] <= 1'b0;
    wt(4);
    u_ist_ctrl_model.send(0);
    wt(4);
    cmp(16'({n_lr[3:0], aw}), 16'h0005);
    @(posedge clk) lv[0] <= 1'b1;
  endtask : s_trig
  task automatic s_status();
    rreg(ist_pkg::SEL_EVENT, 16'h0020);
    rreg(ist_pkg::SEL_EVENT, 16'h0000);
    wreg(ist_pkg::SEL_RISE, 16'h0000);
    wreg(ist_pkg::SEL_FALL, 16'h0100);
    wreg(ist_pkg::SEL_ENABLE, 16'h0100);
    @(posedge clk) lv[2] <= 1'b1;
    wt(5);
    rreg(ist_pkg::SEL_COND, 16'h0120);
    rreg(ist_pkg::SEL_EVENT, 16'h0000);
    @(posedge clk) lv[2] <= 1'b0;
    wt(5);
    cmp(16'(sum[7]), 16'h0001);
    wreg(ist_pkg::SEL_COND, 16'hFFFF);
    rreg(ist_pkg::SEL_COND, 16'h0020);
    rreg(ist_pkg::SEL_EVENT, 16'h0100);
    cmp(16'(sum[7]), 16'h0000);
    @(posedge clk) lv[9] <= 1'b1;
    lv[4] <= 1'b1;
    wt(5);
    cmp(16'(sum), 16'h0058);
    pul(7);
    rreg(ist_pkg::SEL_RISE, 16'h0521);
    rreg(ist_pkg::SEL_FALL, 16'h0000);
    rreg(ist_pkg::SEL_ENABLE, 16'h0000);
  endtask : s_status
  // Remaining live inputs and standard events, then recall, reset and clear commands
  task automatic s_cmds();
    @(posedge clk) lv[8:5] <= 4'hF;
    lv[3] <= 1'b1;
    lv[1] <= 1'b1;
    se <= 8'h24;
    @(posedge clk) se <= 8'h00;
    wt(5);
    rreg(ist_pkg::SEL_FAULT, 16'h0613);
    rreg(ist_pkg::SEL_COND, 16'h0421);
    rreg(ist_pkg::SEL_STDEVT, 16'h0024);
    pul(4);
    wt(2);
    cmp(16'({n_lr[3:0], aw}), 16'h0007);
    pul(5);
    wt(2);
    cmp(16'({n_lr[3:0], ca, aw}), 16'h0010);
    pul(6);
    rreg(ist_pkg::SEL_EVENT, 16'h0000);
  endtask : s_cmds
  // Main sequence, with a watchdog that ends a hung run as a failure
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    wt(4);
    s_reset();
    s_errors();
    s_trig();
    s_status();
    s_cmds();
    stop_test();
  end
  initial begin
    #400000;
    num_errors++;
    stop_test();
  end
endmodule : ist_status_trigger_tb
